// ===== inc/bpm_pkg.sv
// constants, register map and state types of the bus performance monitor
package bpm_pkg;
    localparam int DW = 32;
    localparam int AW = 12;
    localparam int EVT_W = 32;
    localparam int MA_W = 29;
    // register byte addresses
    localparam logic [AW-1:0] ADDR_CTRL = 12'hF00;
    localparam logic [AW-1:0] ADDR_CNT0 = 12'hF40;
    localparam logic [AW-1:0] ADDR_CNT1 = 12'hF80;
    localparam logic [AW-1:0] ADDR_MISS = 12'hFC0;
    // performance_control fields
    localparam int MASK_HI = 31;
    localparam int MASK_LO = 24;
    localparam int STOP1_BIT = 23;
    localparam int GO1_BIT = 22;
    localparam int SEL1_HI = 20;
    localparam int SEL1_LO = 16;
    localparam int STOP0_BIT = 15;
    localparam int GO0_BIT = 14;
    localparam int SEL0_HI = 12;
    localparam int SEL0_LO = 8;
    localparam int NODE8_BIT = 4;
    localparam int RATE_HI = 3;
    localparam int RATE_LO = 2;
    localparam int WRAP1_BIT = 1;
    localparam int WRAP0_BIT = 0;
    // sampled_miss_address fields
    localparam int NEW_BIT = 31;
    localparam int CAUSE_HI = 30;
    localparam int CAUSE_LO = 29;
    localparam int LAYOUT_NEW_REV = 3;
    // node numbering
    localparam logic [3:0] IO_NODE = 4'h8;
    // event input indices
    localparam int EV_VB_HIT = 8;
    localparam int EV_MAILBOX = 11;
    localparam int EV_BUS_RD = 15;
    localparam int EV_BUS_WR = 16;
    localparam int EV_VICTIM = 17;
    localparam int EV_BUS_CMD = 20;
    localparam int EV_VB_SWAP = 31;
    // event pick codes where the mapping bends
    localparam logic [4:0] CODE_VB_HIT = 5'h08;
    localparam logic [4:0] CODE_MBOX_DUP = 5'h0C;
    localparam logic [4:0] CODE_LAST_LOW = 5'h14;
    localparam logic [4:0] CODE_CARRY = 5'h15;
    localparam logic [4:0] CODE_STEP1 = 5'h01;
    localparam logic [4:0] CODE_STEP2 = 5'h02;
    // miss sampling rates
    localparam logic [1:0] RATE_32 = 2'h0;
    localparam logic [1:0] RATE_64 = 2'h1;
    localparam logic [1:0] RATE_ALL = 2'h2;
    localparam logic [8:0] N_32 = 9'h020;
    localparam logic [8:0] N_64 = 9'h040;
    localparam logic [8:0] N_ALL = 9'h001;
    localparam logic [8:0] N_256 = 9'h100;
    localparam logic [DW-1:0] CNT_MAX = 32'hFFFFFFFF;

    typedef struct packed {
        logic [7:0] mask;
        logic node8;
        logic [4:0] sel1;
        logic [4:0] sel0;
        logic [1:0] rate;
        logic run1;
        logic run0;
        logic wrap1;
        logic wrap0;
        logic [DW-1:0] cnt1;
        logic [DW-1:0] cnt0;
        logic [DW-1:0] prdata;
        logic pready;
        logic pslverr;
    } bpm_top_st_t;

    typedef struct packed {
        logic [8:0] seen;
        logic [MA_W-1:0] addr;
        logic [1:0] cause;
        logic fresh;
    } bpm_smp_st_t;

    localparam bpm_top_st_t TOP_RST = '0;
    localparam bpm_smp_st_t SMP_RST = '0;
endpackage

// ===== inc/bpm_miss_if.sv
// link between the register block and the miss address sampler
`timescale 1ns/100ps
interface bpm_miss_if;
    logic [1:0] rate;
    logic load_en;
    logic [28:0] load_addr;
    logic read_ack;
    logic miss_valid;
    logic [28:0] miss_addr;
    logic [1:0] miss_cause;
    logic [28:0] cap_addr;
    logic [1:0] cap_cause;
    logic fresh;
    modport sampler (
        input rate, load_en, load_addr, read_ack, miss_valid, miss_addr, miss_cause,
        output cap_addr, cap_cause, fresh
    );
    modport owner (
        output rate, load_en, load_addr, read_ack, miss_valid, miss_addr, miss_cause,
        input cap_addr, cap_cause, fresh
    );
endinterface

// ===== design/bpm_miss_sampler.sv
// captures every nth backup-cache miss address and its cause
`timescale 1ns/100ps
module bpm_miss_sampler
    import bpm_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic reset, // synchronous reset
    bpm_miss_if.sampler mi // control and capture link
);
    bpm_smp_st_t st_reg;
    bpm_smp_st_t st_next;

    function automatic logic [8:0] nth(input logic [1:0] r);
        logic [8:0] n;
        n = N_256;
        if (r == RATE_32)
            n = N_32;
        else if (r == RATE_64)
            n = N_64;
        else if (r == RATE_ALL)
            n = N_ALL;
        return n;
    endfunction

    always_comb
    begin
        logic [8:0] seen_inc;
        seen_inc = st_reg.seen + 9'h001;
        st_next = st_reg;
        if (mi.read_ack)
            st_next.fresh = 1'b0;
        if (mi.load_en)
            st_next.addr = mi.load_addr;
        if (mi.miss_valid)
        begin
            if (seen_inc >= nth(mi.rate))
            begin
                st_next.seen = '0;
                st_next.addr = mi.miss_addr;
                st_next.cause = mi.miss_cause;
                st_next.fresh = 1'b1;
            end
            else
            begin
                st_next.seen = seen_inc;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            st_reg <= SMP_RST;
        else
            st_reg <= st_next;
    end

    assign mi.cap_addr = st_reg.addr;
    assign mi.cap_cause = st_reg.cause;
    assign mi.fresh = st_reg.fresh;
endmodule

// ===== design/bpm_top.sv
// bus performance monitor: two event counters, control and miss capture on APB
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module bpm_top
    import bpm_pkg::*;
#(
    parameter int IFACE_REV = LAYOUT_NEW_REV // revision of the miss address layout
)
(
    input wire logic ref_clk, // 10 MHz clock
    input wire logic reset, // synchronous, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [AW-1:0] paddr, // apb byte address
    input wire logic [DW-1:0] pwdata, // apb write data
    output logic [DW-1:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [EVT_W-1:0] evt_pulse, // one bit per event source
    input wire logic [3:0] evt_node, // node of the masked bus events
    input wire logic miss_valid, // backup-cache miss pulse
    input wire logic [MA_W-1:0] miss_addr, // block address of the miss
    input wire logic [1:0] miss_cause // miss cause code
);
    bpm_top_st_t st_reg;
    bpm_top_st_t st_next;
    bpm_miss_if mi ();

    logic [EVT_W-1:0] ev0;
    logic [EVT_W-1:0] ev1;
    logic ok0;
    logic ok1;
    logic hit0;
    logic hit1;
    logic carry1;
    logic carry0;
    logic setup;
    logic access;
    logic [DW-1:0] miss_view;
    logic [DW-1:0] ctrl_view;

    // node mask lookup, node 8 only reachable through the ninth bit
    function automatic logic node_ok(input logic [8:0] m, input logic [3:0] n);
        logic r;
        r = 1'b0;
        if (n <= IO_NODE)
            r = m[n];
        return r;
    endfunction

    // event selection shared by both counters
    function automatic logic pick(
        input logic [4:0] code,
        input logic [EVT_W-1:0] ev,
        input logic carry,
        input logic second
    );
        logic r;
        logic [4:0] idx;
        idx = code;
        r = 1'b0;
        if (code <= CODE_LAST_LOW)
        begin
            if (code == CODE_MBOX_DUP)
                idx = EV_MAILBOX[4:0];
            else if (code > CODE_MBOX_DUP)
                idx = code - CODE_STEP1;
            r = ev[idx];
            if (second && code == CODE_VB_HIT)
                r = ev[EV_VB_SWAP];
        end
        else if (second)
        begin
            idx = code - CODE_STEP1;
            r = ev[idx];
        end
        else if (code == CODE_CARRY)
        begin
            r = carry;
        end
        else
        begin
            idx = code - CODE_STEP2;
            r = ev[idx];
        end
        return r;
    endfunction

    assign setup = psel && !penable;
    assign access = psel && penable && st_reg.pready;

    always_comb
    begin
        ok0 = node_ok({1'b0, st_reg.mask}, evt_node);
        ok1 = node_ok({st_reg.node8, st_reg.mask}, evt_node);
        ev0 = evt_pulse;
        ev1 = evt_pulse;
        ev0[EV_BUS_RD] = evt_pulse[EV_BUS_RD] & ok0;
        ev0[EV_BUS_WR] = evt_pulse[EV_BUS_WR] & ok0;
        ev0[EV_VICTIM] = evt_pulse[EV_VICTIM] & ok0;
        ev1[EV_BUS_RD] = evt_pulse[EV_BUS_RD] & ok1;
        ev1[EV_BUS_WR] = evt_pulse[EV_BUS_WR] & ok1;
        ev1[EV_VICTIM] = evt_pulse[EV_VICTIM] & ok1;
        ev1[EV_BUS_CMD] = evt_pulse[EV_BUS_CMD] & ok1;
    end

    assign hit1 = pick(st_reg.sel1, ev1, 1'b0, 1'b1);
    assign carry1 = st_reg.run1 && hit1 && st_reg.cnt1 == CNT_MAX;
    assign hit0 = pick(st_reg.sel0, ev0, carry1, 1'b0);
    assign carry0 = st_reg.run0 && hit0 && st_reg.cnt0 == CNT_MAX;

    always_comb
    begin
        ctrl_view = '0;
        ctrl_view[MASK_HI:MASK_LO] = st_reg.mask;
        ctrl_view[SEL1_HI:SEL1_LO] = st_reg.sel1;
        ctrl_view[SEL0_HI:SEL0_LO] = st_reg.sel0;
        ctrl_view[NODE8_BIT] = st_reg.node8;
        ctrl_view[RATE_HI:RATE_LO] = st_reg.rate;
        ctrl_view[WRAP1_BIT] = st_reg.wrap1;
        ctrl_view[WRAP0_BIT] = st_reg.wrap0;
        // reserved and write-only bits stay zero
        miss_view = '0;
        miss_view[MA_W-1:0] = mi.cap_addr;
        if (IFACE_REV >= LAYOUT_NEW_REV)
        begin
            miss_view[NEW_BIT] = mi.fresh;
            miss_view[CAUSE_HI:CAUSE_LO] = mi.cap_cause;
        end
    end

    always_comb
    begin
        st_next = st_reg;
        st_next.pready = 1'b0;

        if (st_reg.run1 && hit1)
        begin
            st_next.cnt1 = st_reg.cnt1 + 32'h00000001;
            if (st_reg.cnt1 == CNT_MAX)
                st_next.wrap1 = 1'b1;
        end

        if (st_reg.run0 && hit0)
        begin
            st_next.cnt0 = st_reg.cnt0 + 32'h00000001;
            if (st_reg.cnt0 == CNT_MAX)
                st_next.wrap0 = 1'b1;
        end

        // answer prepared in the setup cycle, ready in the first access cycle
        if (setup)
        begin
            st_next.pready = 1'b1;
            st_next.pslverr = 1'b0;
            st_next.prdata = '0;
            if (paddr == ADDR_CTRL)
                st_next.prdata = ctrl_view;
            else if (paddr == ADDR_CNT0)
                st_next.prdata = st_reg.cnt0;
            else if (paddr == ADDR_CNT1)
                st_next.prdata = st_reg.cnt1;
            else if (paddr == ADDR_MISS)
                st_next.prdata = miss_view;
            else
                st_next.pslverr = 1'b1;
        end

        if (access && pwrite)
        begin
            if (paddr == ADDR_CTRL)
            begin
                st_next.mask = pwdata[MASK_HI:MASK_LO];
                st_next.sel1 = pwdata[SEL1_HI:SEL1_LO];
                st_next.sel0 = pwdata[SEL0_HI:SEL0_LO];
                st_next.node8 = pwdata[NODE8_BIT];
                st_next.rate = pwdata[RATE_HI:RATE_LO];
                if (pwdata[STOP1_BIT])
                    st_next.run1 = 1'b0;
                else if (pwdata[GO1_BIT])
                    st_next.run1 = 1'b1;
                if (pwdata[STOP0_BIT])
                    st_next.run0 = 1'b0;
                else if (pwdata[GO0_BIT])
                    st_next.run0 = 1'b1;
            end
            else if (paddr == ADDR_CNT0)
            begin
                st_next.cnt0 = '0;
                // an overflow in this same edge still sets the flag
                st_next.wrap0 = carry0;
                st_next.run0 = 1'b0;
            end
            else if (paddr == ADDR_CNT1)
            begin
                st_next.cnt1 = '0;
                // an overflow in this same edge still sets the flag
                st_next.wrap1 = carry1;
                st_next.run1 = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            st_reg <= TOP_RST;
        else
            st_reg <= st_next;
    end

    assign mi.rate = st_reg.rate;
    assign mi.load_en = access && pwrite && paddr == ADDR_MISS;
    assign mi.load_addr = pwdata[MA_W-1:0];
    // flag cleared as the read data is taken
    assign mi.read_ack = setup && !pwrite && paddr == ADDR_MISS;
    assign mi.miss_valid = miss_valid;
    assign mi.miss_addr = miss_addr;
    assign mi.miss_cause = miss_cause;

    bpm_miss_sampler u_sampler (
        .ref_clk(ref_clk),
        .reset(reset),
        .mi(mi)
    );

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
endmodule

// ===== testbench/bpm_monitor.sv
// port checker for the bus performance monitor
`timescale 1ns/100ps
module bpm_checker
    import bpm_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic reset, // sync reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // direction
    input wire logic [AW-1:0] paddr, // address
    input wire logic [DW-1:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr // error
);
    logic setup;
    logic hit;
    assign setup = psel && !penable;
    assign hit = paddr inside {ADDR_CTRL, ADDR_CNT0, ADDR_CNT1, ADDR_MISS};
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    property p_ready_lat;
        setup |=> pready;
    endproperty
    a_ready_lat: assert property (p_ready_lat) else $error("ready late");
    property p_ready_once;
        pready |=> !pready;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready too long");
    property p_ready_cause;
        pready |-> $past(setup);
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
    property p_err_unmapped;
        setup && !hit |=> pready && pslverr && prdata == '0;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
    property p_err_mapped;
        setup && hit |=> !pslverr;
    endproperty
    a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");
    property p_ctrl_rsvd;
        pready && !pwrite && paddr == ADDR_CTRL |->
            prdata[23:21] == 3'h0 && prdata[15:13] == 3'h0 && prdata[7:5] == 3'h0;
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control bits not zero");
    property p_rdata_hold;
        !setup |=> $stable(prdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_reset_quiet;
        disable iff (1'b0) reset |=> !pready && !pslverr && prdata == '0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    c_ctrl_read: cover property (pready && !pwrite && paddr == ADDR_CTRL);
    c_refused: cover property (pready && pslverr);
    c_miss_new: cover property (pready && paddr == ADDR_MISS && prdata[31]);
endmodule
bind bpm_top bpm_checker chk_u (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

// ===== testbench/bpm_event_src.sv
// event and miss source standing in for the bus interface and cache logic
`timescale 1ns/100ps
module bpm_event_src
    import bpm_pkg::*;
(
    input wire logic ref_clk, // clock
    output logic [EVT_W-1:0] evt_pulse, // events
    output logic [3:0] evt_node, // node
    output logic miss_valid, // miss pulse
    output logic [MA_W-1:0] miss_addr, // address
    output logic [1:0] miss_cause // cause
);
    initial
    begin
        evt_pulse = '0;
        evt_node = 4'hF;
        miss_valid = 1'b0;
        miss_addr = '0;
        miss_cause = 2'h0;
    end
    // n back-to-back cycles of events from one node
    task automatic fire(input logic [EVT_W-1:0] bits, input logic [3:0] node, input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            evt_pulse <= bits;
            evt_node <= node;
        end
        @(posedge ref_clk);
        evt_pulse <= '0;
        evt_node <= ~node;
    endtask
    // address and cause are garbage outside the pulse
    task automatic miss(input logic [MA_W-1:0] a, input logic [1:0] c);
        @(posedge ref_clk);
        miss_valid <= 1'b1;
        miss_addr <= a;
        miss_cause <= c;
        @(posedge ref_clk);
        miss_valid <= 1'b0;
        miss_addr <= ~a;
        miss_cause <= ~c;
    endtask
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the bus performance monitor
`timescale 1ns/100ps
module tb_top
    import bpm_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [AW-1:0] paddr = '0;
    logic [DW-1:0] pwdata = '0;
    logic [DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [EVT_W-1:0] evt_pulse;
    logic [3:0] evt_node;
    logic miss_valid;
    logic [MA_W-1:0] miss_addr;
    logic [1:0] miss_cause;
    logic [DW-1:0] rd;
    logic [DW-1:0] rd_old;
    logic [DW-1:0] prdata_old;
    logic pready_old;
    logic pslverr_old;
    logic [DW-1:0] last;
    logic er;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int ev;
    always #50 ref_clk = ~ref_clk;
    bpm_top dut_u (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .evt_pulse(evt_pulse), .evt_node(evt_node), .miss_valid(miss_valid),
        .miss_addr(miss_addr), .miss_cause(miss_cause)
    );
    // second copy in the older miss layout, sharing every input
    bpm_top #(.IFACE_REV(2)) dut_old_u (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata_old), .pready(pready_old),
        .pslverr(pslverr_old), .evt_pulse(evt_pulse), .evt_node(evt_node),
        .miss_valid(miss_valid), .miss_addr(miss_addr), .miss_cause(miss_cause)
    );
    bpm_event_src src_u (
        .ref_clk(ref_clk), .evt_pulse(evt_pulse), .evt_node(evt_node),
        .miss_valid(miss_valid), .miss_addr(miss_addr), .miss_cause(miss_cause)
    );
    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk iff pready === 1'b1);
        rd = prdata;
        rd_old = prdata_old;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        apb(1'b0, a, '0);
        check(rd, exp);
    endtask
    // r holds stop one, go one, stop zero, go zero; lo holds node 8 and rate
    function automatic logic [DW-1:0] ctl(input logic [7:0] m, input logic [4:0] s1,
        input logic [4:0] s0, input logic [3:0] r, input logic [2:0] lo);
        return {m, r[3:2], 1'b0, s1, r[1:0], 1'b0, s0, 3'h0, lo, 2'h0};
    endfunction
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            fails++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        rdchk(ADDR_CNT0, '0);
        rdchk(ADDR_CNT1, '0);
        rdchk(ADDR_CTRL, '0);
        rdchk(ADDR_MISS, '0);
        rdchk(12'hF10, '0);
        check({31'h0, er}, 32'h1);
        $display("test reset done");
        apb(1'b1, ADDR_CTRL, '1);
        rdchk(ADDR_CTRL, 32'hFF1F1F1C);
        src_u.fire(32'h6000_0000, 4'h0, 2);
        rdchk(ADDR_CNT1, '0);
        rdchk(ADDR_CNT0, '0);
        $display("test control done");
        for (int c = 0; c < 32; c++)
        begin
            ev = c < 12 ? c : (c < 21 ? c - 1 : c - 2);
            if (c == 21)
                continue;
            apb(1'b1, ADDR_CNT0, 32'hFFFF);
            apb(1'b1, ADDR_CTRL, ctl(8'hFF, 5'h0, 5'(c), 4'b0001, 3'h0));
            src_u.fire(32'h1 << ev, 4'h0, 2);
            rdchk(ADDR_CNT0, 32'h2);
        end
        for (int c = 21; c < 32; c++)
        begin
            apb(1'b1, ADDR_CNT1, '0);
            apb(1'b1, ADDR_CTRL, ctl(8'hFF, 5'(c), 5'h0, 4'b0100, 3'h4));
            src_u.fire(32'h1 << (c - 1), 4'h0, 2);
            rdchk(ADDR_CNT1, 32'h2);
        end
        $display("test event codes done");
        apb(1'b1, ADDR_CNT0, '0);
        apb(1'b1, ADDR_CNT1, '0);
        apb(1'b1, ADDR_CTRL, ctl(8'h88, 5'h15, 5'h10, 4'b0101, 3'h0));
        src_u.fire(32'h0010_8000, 4'h3, 1);
        src_u.fire(32'h0010_8000, 4'h7, 1);
        src_u.fire(32'h0010_8000, 4'h5, 1);
        src_u.fire(32'h0010_8000, 4'h8, 1);
        rdchk(ADDR_CNT1, 32'h2);
        rdchk(ADDR_CNT0, 32'h2);
        apb(1'b1, ADDR_CTRL, ctl(8'h88, 5'h15, 5'h10, 4'b0000, 3'h4));
        src_u.fire(32'h0010_8000, 4'h8, 1);
        rdchk(ADDR_CNT1, 32'h3);
        rdchk(ADDR_CNT0, 32'h2);
        apb(1'b1, ADDR_CTRL, ctl(8'h88, 5'h15, 5'h10, 4'b0010, 3'h4));
        src_u.fire(32'h0010_8000, 4'h3, 2);
        rdchk(ADDR_CNT0, 32'h2);
        apb(1'b1, ADDR_CTRL, ctl(8'h88, 5'h15, 5'h10, 4'b0001, 3'h4));
        src_u.fire(32'h0010_8000, 4'h3, 1);
        rdchk(ADDR_CNT0, 32'h3);
        apb(1'b1, ADDR_CNT0, 32'hFFFF_FFFF);
        src_u.fire(32'h0010_8000, 4'h3, 1);
        rdchk(ADDR_CNT0, '0);
        rdchk(ADDR_CNT1, 32'h7);
        apb(1'b1, ADDR_CTRL, ctl(8'h88, 5'h15, 5'h10, 4'b1000, 3'h4));
        src_u.fire(32'h0010_8000, 4'h3, 1);
        rdchk(ADDR_CNT1, 32'h7);
        $display("test mask and run done");
        apb(1'b1, ADDR_CNT1, '0);
        apb(1'b1, ADDR_CTRL, ctl(8'h00, 5'h08, 5'h08, 4'b0101, 3'h2));
        src_u.fire(32'h0000_0100, 4'h0, 3);
        src_u.fire(32'h8000_0100, 4'h0, 2);
        rdchk(ADDR_CNT0, 32'h5);
        rdchk(ADDR_CNT1, 32'h2);
        for (int k = 0; k < 4; k++)
        begin
            src_u.miss(29'h0ABC_DE0 + 29'(k), 2'(k));
            rdchk(ADDR_MISS, {1'b1, 2'(k), 29'h0ABC_DE0 + 29'(k)});
            check(rd_old, {3'h0, 29'h0ABC_DE0 + 29'(k)});
        end
        last = {3'h3, 29'h0ABC_DE3};
        rdchk(ADDR_MISS, last);
        for (int r = 0; r < 4; r++)
        begin
            if (r == 2)
                continue;
            apb(1'b1, ADDR_CTRL, ctl(8'h00, 5'h08, 5'h08, 4'b0000, 3'(r)));
            ev = r == 0 ? 32 : (r == 1 ? 64 : 256);
            repeat (ev - 1) src_u.miss(29'h1F0_0000, 2'h2);
            rdchk(ADDR_MISS, last);
            src_u.miss(29'h0123_450 + 29'(r), 2'h2);
            last = {3'h6, 29'h0123_450 + 29'(r)};
            rdchk(ADDR_MISS, last);
            last[31] = 1'b0;
        end
        apb(1'b1, ADDR_MISS, 32'hFFFF_FFFF);
        rdchk(ADDR_MISS, 32'h5FFF_FFFF);
        check(rd_old, 32'h1FFF_FFFF);
        $display("test miss capture done");
        wrap_up();
    end
endmodule
